// >>> src/fbpc_regs.vh
`ifndef FBPC_REGS_VH
`define FBPC_REGS_VH

// ************************************************************
// command opcodes
// ************************************************************
`define FBPC_OP_WRITE_ENABLE_CMD_EN    8'h06
`define FBPC_OP_WRDIS      8'h04
`define FBPC_OP_STAT_RD    8'h05
`define FBPC_OP_MAP_RD     8'h72
`define FBPC_OP_MAP_WR     8'h42
`define FBPC_OP_MAP_FRZ    8'h8d
`define FBPC_OP_NV_FRZ     8'he8
`define FBPC_OP_UNLOCK     8'h98

// ************************************************************
// frame sizes in bits
// ************************************************************
`define FBPC_MAP_BITS      144
`define FBPC_CMD_BITS      9'h008
`define FBPC_QDUMMY_END    9'h010
`define FBPC_DATA_END      9'h098
`define FBPC_CNT_MAX       9'h1fc

// ************************************************************
// map layout and reset values
// ************************************************************
`define FBPC_WL_MASK       {16'h5555, 128'hffffffffffffffffffffffffffffffff}
`define FBPC_MAP_RST       144'h0
`define FBPC_NV_RST        144'h0
`define FBPC_PAR_BASE      8'h80
`define FBPC_HALF_TOP      8'h88
`define FBPC_BIT_32K_TOP   7'h7f
`define FBPC_BIT_32K_BOT   7'h7e

// ************************************************************
// status byte fields
// ************************************************************
`define FBPC_ST_BUSY       0
`define FBPC_ST_WEL        1

// ************************************************************
// timing
// ************************************************************
`define FBPC_PPT_NS        1500000
`define FBPC_CLK_NS        10

`endif

// >>> src/fbpc_ctrl.v
// Function
// RULE_01: host sends write-enable before a protection map write.
// RULE_02: map write is opcode 42H then 18 data cycles, then chip select rises.
// RULE_03: shifted data is most significant bit or nibble first.
// RULE_04: after freeze, every further protection map change is rejected.
// RULE_05: freeze is volatile and clears only at power-up reset.
// RULE_06: host sends write-enable before the freeze command.
// RULE_07: freeze is opcode 8DH alone, no address or data.
// RULE_08: non-volatile lock bits decide which write-lock bits may change.
// RULE_09: host sends write-enable before the non-volatile lock command.
// RULE_10: non-volatile lock command is opcode E8H plus 18 data cycles.
// RULE_11: chip select rise starts timed program; only status read meanwhile.
// RULE_12: host polls busy or waits the page program time.
// RULE_13: global unlock clears write-lock bits not held by non-volatile locks.
// RULE_14: global unlock is opcode 98H alone.
// RULE_15: host sends write-enable before global unlock.
// RULE_16: parameter blocks map to read/write pairs 143/142 down to 129/128.
// RULE_17: 32 KByte blocks have write-lock bits 127 and 126 only.
// RULE_18: 64 KByte blocks map from bit 125 at 7E0000H downward.
// RULE_19: opcode 06H sets the write-enable latch.
// RULE_20: map readout is msb first, then zeros until chip select rises.
// RULE_21: protection commands need the latch and clear it when done.
// RULE_22: write-lock blocks program/erase; read-lock blocks parameter reads.
// RULE_23: a map write keeps write-lock bits held by non-volatile locks.
`include "fbpc_regs.vh"

module fbpc_ctrl #(
  parameter PROG_CYCLES = (`FBPC_PPT_NS + `FBPC_CLK_NS - 1) / `FBPC_CLK_NS
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // serial link
  input wire ce_n_i,
  input wire sck_i,
  input wire [3:0] sio_i,
  output wire [3:0] sio_o,
  output wire [3:0] sio_oe_o,
  // framing mode
  input wire quad_mode_i,
  // array access check
  input wire [22:0] chk_addr_i,
  output wire prog_blocked_o,
  output wire read_blocked_o,
  // status
  output wire wel_o,
  output wire busy_o,
  output wire frozen_o,
  output wire [143:0] prot_map_o
);

  // ************************************************************
  // input synchronisers
  // ************************************************************
  reg [2:0] ce_s_reg;
  reg [2:0] sck_s_reg;
  reg [3:0] sio_s1_reg;
  reg [3:0] sio_s2_reg;

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      ce_s_reg <= 3'h7;
      sck_s_reg <= 3'h0;
      sio_s1_reg <= 4'h0;
      sio_s2_reg <= 4'h0;
    end else begin
      ce_s_reg <= {ce_s_reg[1:0], ce_n_i};
      sck_s_reg <= {sck_s_reg[1:0], sck_i};
      sio_s1_reg <= sio_i;
      sio_s2_reg <= sio_s1_reg;
    end
  end

  wire ce_n = ce_s_reg[1];
  wire ce_rise = ce_s_reg[1] & ~ce_s_reg[2];
  wire sck_rise = sck_s_reg[1] & ~sck_s_reg[2] & ~ce_n;
  wire sck_fall = ~sck_s_reg[1] & sck_s_reg[2] & ~ce_n;

  // ************************************************************
  // state
  // ************************************************************
  reg [143:0] map_reg;
  reg [143:0] nv_reg;
  reg [143:0] sh_reg;
  reg [143:0] out_reg;
  reg [8:0] cnt_reg;
  reg [7:0] op_reg;
  reg tx_reg;
  reg quad_reg;
  reg wel_reg;
  reg frz_reg;
  reg busy_reg;
  reg [31:0] tmr_reg;
  reg [3:0] sio_reg;
  reg [3:0] oe_reg;
  reg prog_blk_reg;
  reg read_blk_reg;

  wire [143:0] wl_mask = `FBPC_WL_MASK;
  wire [143:0] held = nv_reg & wl_mask;
  wire [7:0] status = {6'h00, wel_reg, busy_reg};

  // ************************************************************
  // shift and count
  // ************************************************************
  wire [143:0] sh_next = quad_reg ? {sh_reg[139:0], sio_s2_reg} :
                         {sh_reg[142:0], sio_s2_reg[0]}; // [RULE_03]
  wire [8:0] step = quad_reg ? 9'h004 : 9'h001;
  wire [8:0] cnt_sum = cnt_reg + step;
  wire [8:0] cnt_next = (cnt_reg >= `FBPC_CNT_MAX) ? cnt_reg : cnt_sum;
  wire [7:0] op_now = (cnt_next == `FBPC_CMD_BITS) ? sh_next[7:0] : op_reg;
  wire is_rd_map = (op_now == `FBPC_OP_MAP_RD) & ~busy_reg; // [RULE_11]
  wire is_rd_st = (op_now == `FBPC_OP_STAT_RD);
  wire rd_point = quad_reg ? (cnt_next == `FBPC_QDUMMY_END) :
                  (cnt_next == `FBPC_CMD_BITS);
  wire rd_start = rd_point & (is_rd_map | is_rd_st);

  // ************************************************************
  // command decode at chip select rise
  // ************************************************************
  wire cmd_only = (cnt_reg == `FBPC_CMD_BITS);
  wire data_full = (cnt_reg == `FBPC_DATA_END);
  wire may_exec = ce_rise & ~busy_reg & wel_reg; // [RULE_11] [RULE_21]
  wire do_write_enable_cmd = ce_rise & ~busy_reg & cmd_only &
                 (op_reg == `FBPC_OP_WRITE_ENABLE_CMD_EN); // [RULE_19]
  wire do_wrdis = ce_rise & ~busy_reg & cmd_only &
                  (op_reg == `FBPC_OP_WRDIS);
  wire do_map_wr = may_exec & data_full & ~frz_reg &
                   (op_reg == `FBPC_OP_MAP_WR); // [RULE_02] [RULE_04]
  wire do_frz = may_exec & cmd_only &
                (op_reg == `FBPC_OP_MAP_FRZ); // [RULE_07]
  wire do_nv = may_exec & data_full &
               (op_reg == `FBPC_OP_NV_FRZ); // [RULE_10]
  wire do_unlock = may_exec & cmd_only & ~frz_reg &
                   (op_reg == `FBPC_OP_UNLOCK); // [RULE_14] [RULE_04]
  wire prot_done = do_map_wr | do_frz | do_nv | do_unlock;

  // ************************************************************
  // serial front end
  // ************************************************************
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      sh_reg <= 144'h0;
      out_reg <= 144'h0;
      cnt_reg <= 9'h000;
      op_reg <= 8'h00;
      tx_reg <= 1'b0;
      quad_reg <= 1'b0;
      sio_reg <= 4'h0;
      oe_reg <= 4'h0;
    end else if (ce_n) begin
      cnt_reg <= (ce_rise) ? cnt_reg : 9'h000;
      tx_reg <= 1'b0;
      oe_reg <= 4'h0;
      sio_reg <= 4'h0;
      quad_reg <= quad_mode_i;
    end else begin
      if (sck_rise) begin
        sh_reg <= sh_next;
        cnt_reg <= cnt_next;
        if (cnt_next == `FBPC_CMD_BITS) begin
          op_reg <= sh_next[7:0];
        end
        if (rd_start) begin
          tx_reg <= 1'b1;
          out_reg <= is_rd_st ? {status, 136'h0} : map_reg; // [RULE_20]
        end
      end
      if (sck_fall && tx_reg) begin
        if (quad_reg) begin
          sio_reg <= out_reg[143:140];
          oe_reg <= 4'hf;
          out_reg <= {out_reg[139:0], 4'h0}; // [RULE_20]
        end else begin
          sio_reg <= {2'b00, out_reg[143], 1'b0};
          oe_reg <= 4'h2;
          out_reg <= {out_reg[142:0], 1'b0}; // [RULE_20]
        end
      end
    end
  end

  // ************************************************************
  // protection state
  // ************************************************************
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      map_reg <= `FBPC_MAP_RST;
      nv_reg <= `FBPC_NV_RST;
      wel_reg <= 1'b0;
      frz_reg <= 1'b0; // [RULE_05]
    end else begin
      if (do_map_wr) begin
        map_reg <= (sh_reg & ~held) | (map_reg & held); // [RULE_23] [RULE_08]
      end else if (do_unlock) begin
        map_reg <= map_reg & ~(wl_mask & ~held); // [RULE_13]
      end
      if (do_nv) begin
        nv_reg <= nv_reg | (sh_reg & wl_mask); // [RULE_08] [RULE_03]
      end
      if (do_frz) begin
        frz_reg <= 1'b1; // [RULE_04]
      end
      if (do_write_enable_cmd) begin
        wel_reg <= 1'b1; // [RULE_19]
      end else if (prot_done || do_wrdis) begin
        wel_reg <= 1'b0; // [RULE_21]
      end
    end
  end

  // ************************************************************
  // self-timed program
  // ************************************************************
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      busy_reg <= 1'b0;
      tmr_reg <= 32'h0;
    end else if (do_nv) begin
      busy_reg <= 1'b1; // [RULE_11]
      tmr_reg <= PROG_CYCLES;
    end else if (busy_reg) begin
      if (tmr_reg <= 32'h1) begin
        busy_reg <= 1'b0;
        tmr_reg <= 32'h0;
      end else begin
        tmr_reg <= tmr_reg - 32'h1;
      end
    end
  end

  // ************************************************************
  // address to map bit
  // ************************************************************
  reg [7:0] wl_idx;
  reg par_blk;

  always @* begin
    wl_idx = 8'h00;
    par_blk = 1'b0;
    if (chk_addr_i[22:15] == 8'hff) begin
      par_blk = 1'b1;
      wl_idx = `FBPC_HALF_TOP + {5'h00, chk_addr_i[14:13], 1'b0}; // [RULE_16]
    end else if (chk_addr_i[22:15] == 8'h00) begin
      par_blk = 1'b1;
      wl_idx = `FBPC_PAR_BASE + {5'h00, chk_addr_i[14:13], 1'b0}; // [RULE_16]
    end else if (chk_addr_i[22:16] == 7'h7f) begin
      wl_idx = {1'b0, `FBPC_BIT_32K_TOP}; // [RULE_17]
    end else if (chk_addr_i[22:16] == 7'h00) begin
      wl_idx = {1'b0, `FBPC_BIT_32K_BOT}; // [RULE_17]
    end else begin
      wl_idx = {1'b0, chk_addr_i[22:16]} - 8'h01; // [RULE_18]
    end
  end

  wire [7:0] rl_idx = wl_idx + 8'h01;

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      prog_blk_reg <= 1'b0;
      read_blk_reg <= 1'b0;
    end else begin
      prog_blk_reg <= map_reg[wl_idx]; // [RULE_22]
      read_blk_reg <= par_blk & map_reg[rl_idx]; // [RULE_22]
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign sio_o = sio_reg;
  assign sio_oe_o = oe_reg;
  assign prog_blocked_o = prog_blk_reg;
  assign read_blocked_o = read_blk_reg;
  assign wel_o = wel_reg;
  assign busy_o = busy_reg;
  assign frozen_o = frz_reg;
  assign prot_map_o = map_reg;

endmodule

// >>> tb/fbpc_ctrl_props.sv
module fbpc_ctrl_props #(
  parameter int PROG_CYCLES = 20
) (
  // clock and reset
  input logic clk_i,
  input logic rst_n_i,
  // watched ports
  input logic ce_n_i,
  input logic [3:0] sio_oe_o,
  input logic [22:0] chk_addr_i,
  input logic prog_blocked_o,
  input logic read_blocked_o,
  input logic wel_o,
  input logic busy_o,
  input logic frozen_o,
  input logic [143:0] prot_map_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // busy length count and properties
  // ************************************************************
  logic [31:0] busy_cnt_reg;
  always @(posedge clk_i) begin
    busy_cnt_reg <= (!rst_n_i || !busy_o) ? 32'h0 : busy_cnt_reg + 32'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence idle_s; ce_n_i [*6]; endsequence
  sequence busy_end_s; busy_o ##1 !busy_o; endsequence
  busy_len_a: assert property (busy_end_s |-> busy_cnt_reg == PROG_CYCLES)
    else $error("busy length wrong");
  busy_hold_a: assert property (busy_o |-> $stable(prot_map_o) && !$rose(wel_o))
    else $error("change while busy");
  busy_wel_a: assert property ($rose(busy_o) |-> !wel_o && $past(wel_o))
    else $error("busy without latch");
  frz_keep_a: assert property (frozen_o |=> frozen_o)
    else $error("freeze lost");
  frz_map_a: assert property (frozen_o |=> $stable(prot_map_o))
    else $error("frozen map changed");
  map_wel_a: assert property (!$stable(prot_map_o) |-> $fell(wel_o))
    else $error("map change without latch");
  top_par_a: assert property (chk_addr_i[22:13] == 10'h3ff |=>
    prog_blocked_o == $past(prot_map_o[142]) && read_blocked_o == $past(prot_map_o[143]))
    else $error("top block lock wrong");
  bot_par_a: assert property (chk_addr_i[22:13] == 10'h000 |=>
    prog_blocked_o == $past(prot_map_o[128]) && read_blocked_o == $past(prot_map_o[129]))
    else $error("bottom block lock wrong");
  half_blk_a: assert property (chk_addr_i[22:15] == 8'hfe |=>
    prog_blocked_o == $past(prot_map_o[127]) && !read_blocked_o)
    else $error("32k lock wrong");
  full_blk_a: assert property (chk_addr_i[22:16] == 7'h7e |=>
    prog_blocked_o == $past(prot_map_o[125]) && !read_blocked_o)
    else $error("64k lock wrong");
  oe_idle_a: assert property (idle_s |-> sio_oe_o == 4'h0)
    else $error("driving while idle");
endmodule

bind fbpc_ctrl fbpc_ctrl_props #(.PROG_CYCLES(PROG_CYCLES)) props_u (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_n_i(ce_n_i), .sio_oe_o(sio_oe_o),
  .chk_addr_i(chk_addr_i), .prog_blocked_o(prog_blocked_o),
  .read_blocked_o(read_blocked_o), .wel_o(wel_o), .busy_o(busy_o),
  .frozen_o(frozen_o), .prot_map_o(prot_map_o));

// >>> tb/fbpc_host.sv
module fbpc_host (
  // clock and mode
  input logic clk_i,
  input logic quad_i,
  // link to device
  output logic ce_n_o,
  output logic sck_o,
  output logic [3:0] sio_o,
  input logic sdo_i,
  input logic sdo_oe_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // host framing, msb first, 16 clk per sck
  // ************************************************************
  initial begin
    ce_n_o = 1'b1;
    sck_o = 1'b0;
    sio_o = 4'h0;
  end
  task automatic frame(input logic [151:0] tx, input int nb, input int nr,
                       output logic [143:0] rx);
    int w;
    rx = '0;
    @(posedge clk_i) ce_n_o <= 1'b0;
    w = quad_i ? 4 : 1;
    for (int i = 0; i < nb + nr; i += w) begin
      sio_o <= (w == 4) ? tx[151 - i -: 4] : {3'h0, tx[151 - i]};
      repeat (8) @(posedge clk_i);
      sck_o <= 1'b1;
      repeat (7) @(posedge clk_i);
      @(negedge clk_i);
      if (i >= nb) rx = {rx[142:0], sdo_oe_i ? sdo_i : ~rx[0]};
      @(posedge clk_i) sck_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    ce_n_o <= 1'b1;
    sio_o <= ~sio_o;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
  endtask
endmodule

// >>> tb/tb_top.sv
`include "fbpc_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic quad_mode_i = 1'b0;
  logic [22:0] chk_addr_i = 23'h0;
  logic ce, sck, prog_blocked_o, read_blocked_o, wel_o, busy_o, frozen_o;
  logic [3:0] sio, sio_o, sio_oe_o;
  logic [143:0] prot_map_o, rx, v, nv, m;
  logic [15:0] seed = 16'h4de2;
  logic [22:0] corner [6] = '{23'h7fe000, 23'h001fff, 23'h7f7fff, 23'h00a000,
                              23'h7e0000, 23'h5e1234};
  int mismatches = 0;
  int n_tests = 0;
  always #5 clk_i = ~clk_i;
  fbpc_ctrl #(.PROG_CYCLES(200)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .ce_n_i(ce), .sck_i(sck), .sio_i(sio), .sio_o(sio_o), .sio_oe_o(sio_oe_o),
    .quad_mode_i(quad_mode_i), .chk_addr_i(chk_addr_i),
    .prog_blocked_o(prog_blocked_o), .read_blocked_o(read_blocked_o),
    .wel_o(wel_o), .busy_o(busy_o), .frozen_o(frozen_o),
    .prot_map_o(prot_map_o));
  fbpc_host host_u (.clk_i(clk_i), .quad_i(quad_mode_i), .ce_n_o(ce),
    .sck_o(sck), .sio_o(sio), .sdo_i(sio_o[1]), .sdo_oe_i(sio_oe_o[1]));
  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [1:0] lk(input logic [22:0] a, input logic [143:0] mp);
    int b;
    b = a[22:16] - 1;
    if (a[22:15] == 8'hfe) b = 127;
    if (a[22:15] == 8'h01) b = 126;
    if (a[22:15] == 8'hff || a[22:15] == 8'h00) begin
      b = 128 + 8 * a[15] + 2 * a[14:13];
      return {mp[b + 1], mp[b]};
    end
    return {1'b0, mp[b]};
  endfunction
  task automatic rnd(output logic [143:0] r);
    repeat (9) begin
      seed = lfsr(seed);
      r = {r[127:0], seed};
    end
  endtask
  task automatic chk(input logic [143:0] got, input logic [143:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] op);
    host_u.frame({op, 144'h0}, 8, 0, rx);
  endtask
  task automatic wrp(input logic [143:0] d);
    cmd(`FBPC_OP_WRITE_ENABLE_CMD_EN);
    chk(wel_o, 1'b1);
    host_u.frame({`FBPC_OP_MAP_WR, d}, 152, 0, rx);
  endtask
  task automatic unlock;
    cmd(`FBPC_OP_WRITE_ENABLE_CMD_EN);
    cmd(`FBPC_OP_UNLOCK);
  endtask
  task automatic addr_chk(input logic [22:0] a);
    @(posedge clk_i) chk_addr_i <= a;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk({read_blocked_o, prog_blocked_o}, lk(a, v));
  endtask
  task automatic report_and_stop;
    if (mismatches == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ************************************************************
  // sequence and watchdog
  // ************************************************************
  initial begin
    repeat (60000) @(posedge clk_i);
    mismatches++;
    report_and_stop;
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rnd(v);
    wrp(v);
    chk(prot_map_o, v);
    chk(wel_o, 1'b0);
    host_u.frame({`FBPC_OP_MAP_RD, 144'h0}, 8, 144, rx);
    chk(rx, v);
    cmd(`FBPC_OP_WRITE_ENABLE_CMD_EN);
    cmd(`FBPC_OP_WRDIS);
    chk(wel_o, 1'b0);
    host_u.frame({`FBPC_OP_MAP_WR, ~v}, 152, 0, rx);
    chk(prot_map_o, v);
    foreach (corner[i]) addr_chk(corner[i]);
    repeat (8) begin
      seed = lfsr(seed);
      addr_chk({seed[6:0], seed});
    end
    @(posedge clk_i) quad_mode_i <= 1'b1;
    rnd(v);
    wrp(v);
    chk(prot_map_o, v);
    unlock();
    chk(prot_map_o, v & ~`FBPC_WL_MASK);
    @(posedge clk_i) quad_mode_i <= 1'b0;
    rnd(nv);
    wrp('1);
    cmd(`FBPC_OP_WRITE_ENABLE_CMD_EN);
    host_u.frame({`FBPC_OP_NV_FRZ, nv}, 152, 0, rx);
    chk({busy_o, wel_o}, 2'b10);
    cmd(`FBPC_OP_WRITE_ENABLE_CMD_EN);
    chk(wel_o, 1'b0);
    rx = '1;
    for (int k = 0; k < 20 && rx[0]; k++)
      host_u.frame({`FBPC_OP_STAT_RD, 144'h0}, 8, 8, rx);
    chk(rx[1:0], 2'b00);
    unlock();
    m = ~`FBPC_WL_MASK | (nv & `FBPC_WL_MASK);
    chk(prot_map_o, m);
    wrp('0);
    m = nv & `FBPC_WL_MASK;
    chk(prot_map_o, m);
    cmd(`FBPC_OP_WRITE_ENABLE_CMD_EN);
    cmd(`FBPC_OP_MAP_FRZ);
    chk(frozen_o, 1'b1);
    wrp(v);
    unlock();
    chk(prot_map_o, m);
    @(posedge clk_i) rst_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    chk(frozen_o, 1'b0);
    wrp(v);
    chk(prot_map_o, v);
    report_and_stop;
  end
endmodule
